/* hw/kpi_pkg.sv */
// Purpose: Constants for the keypad pin interrupt unit
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Register offsets are byte addresses
package kpi_pkg;
	localparam int          KPI_AW          = 4;
	localparam logic [3:0]  KPI_OFF_SC      = 4'h0;
	localparam logic [3:0]  KPI_OFF_PE      = 4'h4;
	localparam logic [3:0]  KPI_OFF_ES      = 4'h8;
	localparam int          KPI_BIT_FLAG    = 3;
	localparam int          KPI_BIT_ACK     = 2;
	localparam int          KPI_BIT_IE      = 1;
	localparam int          KPI_BIT_MOD     = 0;
	localparam logic [7:0]  KPI_PIN_MASK    = 8'h37;
	localparam logic [7:0]  KPI_RST_BYTE    = 8'h00;
	localparam int          KPI_NPINS       = 8;
endpackage : kpi_pkg

/* hw/kpi_keypad_irq_unit.sv */
// Purpose: Keypad pin interrupt unit with APB register access
// Assumes: Pins are asynchronous; one clock pclk at 10 MHz
// Notes:   Slave answers with zero wait states
// Function
// - Detection flag at status bit 3, set by detection, never set by writes.
// - Writing 1 to bit 2 acknowledges; bit 2 always reads 0.
// - Status bit 1 enables the interrupt request.
// - Status bit 0 selects edge only or edge and level detection.
// - Pin enable bits 5, 4 and 2 to 0 make pins interrupt sources.
// - Polarity bit 0 means falling/low, 1 means rising/high.
// - Edges detected synchronously, only after deasserted level sampled.
// - Falling edge is 1 in one cycle, 0 in the next.
// - Rising edge is 0 in one cycle, 1 in the next.
// - Edge mode: edge sets flag, request if enabled, ack clears.
// - Level mode: edge or asserted level sets the flag.
// - Level mode: ack clears only if all enabled pins deasserted.
// - Enabling a pin turns on no pull device.
// - Detection continues in wait and stop; enabled irq wakes processor.
// - Detection continues normally during background debug.
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module kpi_keypad_irq_unit
	import kpi_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [31:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic [kpi_pkg::KPI_NPINS-1:0] key_input_pin,
	output logic                     key_irq
);
	import kpi_pkg::*;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	// Three stages; the second and third agreeing marks a settled change
	logic [KPI_NPINS-1:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
	logic [KPI_NPINS-1:0] pin_q, pin_d;
	logic [KPI_NPINS-1:0] armed_q, armed_d;
	logic [KPI_NPINS-1:0] asserted, edge_hit;

	logic [7:0] pe_q, pe_d, es_q, es_d;
	logic       ie_q, ie_d, mod_q, mod_d, flag_q, flag_d;
	logic [31:0] prdata_d;
	logic       pready_d, pslverr_d, irq_d;
	logic       wr_sc, ack_wr, det_any, lvl_any, unmapped;

	// Per pin asserted level and edge; pins outside the mask never count
	genvar g;
	generate
		for (g = 0; g < KPI_NPINS; g++)
		begin : g_pin
			// Level seen at the filtered input, polarity applied
			assign asserted[g] = pe_q[g] & (pin_q[g] == es_q[g]);
			// Edge needs a deasserted sample in the cycle before
			assign edge_hit[g] = asserted[g] & armed_q[g];
		end
	endgenerate

	always_comb
	begin
		s1_d = key_input_pin;
		s2_d = s1_q;
		s3_d = s2_q;
		pin_d = (s2_q == s3_q) ? s3_q : pin_q;
		// Arm where pin is seen deasserted this cycle
		armed_d = pe_q & ~(pin_q ~^ es_q[KPI_NPINS-1:0]);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_q    <= '0;
			s2_q    <= '0;
			s3_q    <= '0;
			pin_q   <= '0;
			armed_q <= '0;
		end
		else
		begin
			s1_q    <= s1_d;
			s2_q    <= s2_d;
			s3_q    <= s3_d;
			pin_q   <= pin_d;
			armed_q <= armed_d;
		end
	end

	// ------------------------------------------------------------------
	// Registers, flag and APB slave
	// ------------------------------------------------------------------
	always_comb
	begin
		unmapped = (paddr[KPI_AW-1:0] != KPI_OFF_SC) &&
			(paddr[KPI_AW-1:0] != KPI_OFF_PE) &&
			(paddr[KPI_AW-1:0] != KPI_OFF_ES);
		wr_sc  = psel & penable & pwrite & (paddr[KPI_AW-1:0] == KPI_OFF_SC);
		ack_wr = wr_sc & pwdata[KPI_BIT_ACK];
		det_any = |edge_hit;
		lvl_any = |asserted;
		ie_d = ie_q;
		mod_d = mod_q;
		pe_d = pe_q;
		es_d = es_q;
		if (wr_sc)
		begin
			ie_d  = pwdata[KPI_BIT_IE];
			mod_d = pwdata[KPI_BIT_MOD];
		end
		if (psel & penable & pwrite &
			(paddr[KPI_AW-1:0] == KPI_OFF_PE))
			pe_d = pwdata[7:0] & KPI_PIN_MASK;
		if (psel & penable & pwrite &
			(paddr[KPI_AW-1:0] == KPI_OFF_ES))
			es_d = pwdata[7:0] & KPI_PIN_MASK;
		// Set beats ack; writes never set the flag directly
		flag_d = flag_q;
		if (ack_wr && !(mod_q && lvl_any))
			flag_d = 1'b0;
		if (det_any || (mod_q && lvl_any))
			flag_d = 1'b1;
		// Level view: the registered pin tracks the live state
		irq_d = flag_d & ie_d;
		prdata_d = 32'h0000_0000;
		if (psel && !penable && !pwrite)
		begin
			case (paddr[KPI_AW-1:0])
				KPI_OFF_SC: prdata_d = {28'h0, flag_q, 1'b0, ie_q, mod_q};
				KPI_OFF_PE: prdata_d = {24'h0, pe_q};
				KPI_OFF_ES: prdata_d = {24'h0, es_q};
				default:    prdata_d = 32'h0000_0000;
			endcase
		end
		else if (psel && penable)
			prdata_d = prdata;
		pready_d  = psel & ~penable;
		pslverr_d = psel & ~penable & unmapped;
	end

	// Read data captured in setup so it is stable in the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ie_q    <= 1'b0;
			mod_q   <= 1'b0;
			flag_q  <= 1'b0;
			pe_q    <= KPI_RST_BYTE;
			es_q    <= KPI_RST_BYTE;
			key_irq <= 1'b0;
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			ie_q    <= ie_d;
			mod_q   <= mod_d;
			flag_q  <= flag_d;
			pe_q    <= pe_d;
			es_q    <= es_d;
			key_irq <= irq_d;
			prdata  <= prdata_d;
			pready  <= pready_d;
			pslverr <= pslverr_d;
		end
	end
	// No pull device is driven from here; pin enables stay internal

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_irq_and;
		@(posedge pclk) disable iff (!presetn)
		key_irq == (flag_q & ie_q);
	endproperty
	a_irq_and: assert property (p_irq_and) else $error("irq mismatch");

	property p_edge_sets;
		@(posedge pclk) disable iff (!presetn)
		det_any |=> flag_q;
	endproperty
	a_edge_sets: assert property (p_edge_sets) else $error("edge lost");

	property p_level_holds;
		@(posedge pclk) disable iff (!presetn)
		(mod_q && lvl_any) |=> flag_q;
	endproperty
	a_level_holds: assert property (p_level_holds) else $error("lvl");

	property p_ack_clears;
		@(posedge pclk) disable iff (!presetn)
		(ack_wr && !det_any && !mod_q) |=> !flag_q;
	endproperty
	a_ack_clears: assert property (p_ack_clears) else $error("ack");

	property p_no_self_set;
		@(posedge pclk) disable iff (!presetn)
		(!flag_q && !det_any && !(mod_q && lvl_any)) |=> !flag_q;
	endproperty
	a_no_self_set: assert property (p_no_self_set) else $error("set");

	property p_ack_reads0;
		@(posedge pclk) disable iff (!presetn)
		(pready && !pwrite && paddr[KPI_AW-1:0] == KPI_OFF_SC)
			|-> !prdata[KPI_BIT_ACK];
	endproperty
	a_ack_reads0: assert property (p_ack_reads0) else $error("ack rd");

	property p_pe_mask;
		@(posedge pclk) disable iff (!presetn)
		(pe_q & ~KPI_PIN_MASK) == 8'h00;
	endproperty
	a_pe_mask: assert property (p_pe_mask) else $error("pe mask");

	// A polarity change may also arm an edge, so only the prior sample counts
	property p_edge_needs_arm;
		@(posedge pclk) disable iff (!presetn)
		(edge_hit & ~($past(pin_q) ^ $past(es_q))) == 8'h00;
	endproperty
	a_edge_needs_arm: assert property (p_edge_needs_arm)
		else $error("edge");

	property p_ie_write;
		@(posedge pclk) disable iff (!presetn)
		wr_sc |=> ie_q == $past(pwdata[KPI_BIT_IE]);
	endproperty
	a_ie_write: assert property (p_ie_write) else $error("ie");

	property p_ack_level_blocks;
		@(posedge pclk) disable iff (!presetn)
		(ack_wr && mod_q && lvl_any) |=> flag_q;
	endproperty
	a_ack_level_blocks: assert property (p_ack_level_blocks)
		else $error("ack in level mode cleared an asserted pin");

	property p_ack_level_clears;
		@(posedge pclk) disable iff (!presetn)
		(ack_wr && mod_q && !lvl_any && !det_any) |=> !flag_q;
	endproperty
	a_ack_level_clears: assert property (p_ack_level_clears)
		else $error("ack in level mode failed to clear");

	property p_flag_reads;
		@(posedge pclk) disable iff (!presetn)
		(pready && !pwrite && paddr[KPI_AW-1:0] == KPI_OFF_SC)
			|-> prdata[KPI_BIT_FLAG] == $past(flag_q);
	endproperty
	a_flag_reads: assert property (p_flag_reads) else $error("flag rd");

	property p_ie_reads;
		@(posedge pclk) disable iff (!presetn)
		(pready && !pwrite && paddr[KPI_AW-1:0] == KPI_OFF_SC)
			|-> prdata[KPI_BIT_IE] == $past(ie_q);
	endproperty
	a_ie_reads: assert property (p_ie_reads) else $error("ie rd");

	property p_irq_off_ie0;
		@(posedge pclk) disable iff (!presetn)
		!ie_q |-> !key_irq;
	endproperty
	a_irq_off_ie0: assert property (p_irq_off_ie0) else $error("irq");

	property p_es_mask;
		@(posedge pclk) disable iff (!presetn)
		(es_q & ~KPI_PIN_MASK) == 8'h00;
	endproperty
	a_es_mask: assert property (p_es_mask) else $error("es mask");

	property p_rd_upper_zero;
		@(posedge pclk) disable iff (!presetn)
		(pready && !pwrite) |-> prdata[31:8] == 24'h00_0000;
	endproperty
	a_rd_upper_zero: assert property (p_rd_upper_zero)
		else $error("upper read bits not zero");

	property p_unmapped_err;
		@(posedge pclk) disable iff (!presetn)
		pready |-> pslverr == unmapped;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err)
		else $error("pslverr wrong");

	property p_unmapped_read0;
		@(posedge pclk) disable iff (!presetn)
		(pready && !pwrite && unmapped) |-> prdata == 32'h0000_0000;
	endproperty
	a_unmapped_read0: assert property (p_unmapped_read0)
		else $error("unmapped read not zero");

	property p_mod_write;
		@(posedge pclk) disable iff (!presetn)
		wr_sc |=> mod_q == $past(pwdata[KPI_BIT_MOD]);
	endproperty
	a_mod_write: assert property (p_mod_write) else $error("mod");

	property p_pe_write;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && pwrite && paddr[KPI_AW-1:0] == KPI_OFF_PE)
			|=> pe_q == ($past(pwdata[7:0]) & KPI_PIN_MASK);
	endproperty
	a_pe_write: assert property (p_pe_write) else $error("pe wr");

	property p_es_write;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && pwrite && paddr[KPI_AW-1:0] == KPI_OFF_ES)
			|=> es_q == ($past(pwdata[7:0]) & KPI_PIN_MASK);
	endproperty
	a_es_write: assert property (p_es_write) else $error("es wr");

	property p_fall_edge;
		@(posedge pclk) disable iff (!presetn)
		((pe_q & $past(pe_q) & ~es_q & ~$past(es_q) & $past(pin_q) & ~pin_q)
			!= 8'h00) |-> det_any;
	endproperty
	a_fall_edge: assert property (p_fall_edge) else $error("fall");

	property p_rise_edge;
		@(posedge pclk) disable iff (!presetn)
		((pe_q & $past(pe_q) & es_q & $past(es_q) & ~$past(pin_q) & pin_q)
			!= 8'h00) |-> det_any;
	endproperty
	a_rise_edge: assert property (p_rise_edge) else $error("rise");

	property p_disabled_quiet;
		@(posedge pclk) disable iff (!presetn)
		(pe_q == 8'h00 && $past(pe_q) == 8'h00) |-> !det_any && !lvl_any;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet)
		else $error("disabled pin detected");

	property p_sync_settle;
		@(posedge pclk) disable iff (!presetn)
		(pin_q != $past(pin_q)) |-> pin_q == $past(s3_q);
	endproperty
	a_sync_settle: assert property (p_sync_settle) else $error("sync");

	property p_irq_follows_ack;
		@(posedge pclk) disable iff (!presetn)
		(ack_wr && !det_any && !mod_q) |=> !key_irq;
	endproperty
	a_irq_follows_ack: assert property (p_irq_follows_ack)
		else $error("irq held after ack");

	property p_write_keeps_flag;
		@(posedge pclk) disable iff (!presetn)
		(wr_sc && !pwdata[KPI_BIT_ACK] && flag_q) |=> flag_q;
	endproperty
	a_write_keeps_flag: assert property (p_write_keeps_flag)
		else $error("write without ack cleared flag");
endmodule : kpi_keypad_irq_unit
`default_nettype wire

/* test/kpi_pin_model.sv */
// Purpose: Switch model that drives the keypad input pins
// Assumes: Switches always drive a level and never float
// Notes:   Levels move one clock edge after the bench asks for them
`timescale 1ns/1ps
`default_nettype none
module kpi_pin_model
(
	input  wire logic       pclk,
	input  wire logic [7:0] want,
	output logic      [7:0] key_input_pin
);
	// Launched after an edge so the unit never samples mid-change
	always_ff @(posedge pclk)
	begin
		key_input_pin <= want;
	end
endmodule : kpi_pin_model
`default_nettype wire

/* test/testbench.sv */
// Purpose: Register and pin detection checks of the keypad irq unit
// Assumes: Zero wait APB slave; a pin change settles within 12 edges
// Notes:   Fixed settle margin follows the synchroniser depth
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import kpi_pkg::*;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [31:0] paddr   = 32'h0;
	logic [31:0] pwdata  = 32'h0;
	logic [7:0]  want    = 8'hFF;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  pins;
	logic        key_irq;
	logic [31:0] rd;
	logic        err;
	int          fails = 0;
	int          check_count = 0;

	always #50 pclk = ~pclk;

	kpi_pin_model i_pins (.pclk(pclk), .want(want), .key_input_pin(pins));
	kpi_keypad_irq_unit i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .key_input_pin(pins), .key_irq(key_irq));

	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	task automatic apb(input logic wr, input logic [3:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= {28'h0, a};
		pwdata  <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			fails++;
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Let an idle edge pass so the next call never re-raises psel at once
		@(posedge pclk);
	endtask : apb

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		apb(1'b0, a, 8'h00);
		chk("prdata", e, rd);
	endtask : rchk

	task automatic ichk(input logic e);
		chk("key_irq", {31'h0, e}, {31'h0, key_irq});
	endtask : ichk

	// Pin synchroniser and filter need a few edges before the flag
	task automatic pin_set(input logic [7:0] v);
		want <= v;
		repeat (12) @(posedge pclk);
	endtask : pin_set

	task automatic give_verdict;
		if (fails == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk(KPI_OFF_SC, 32'h0);
		rchk(KPI_OFF_PE, 32'h0);
		rchk(KPI_OFF_ES, 32'h0);
		rchk(4'hC, 32'h0);
		chk("pslverr", 32'h1, {31'h0, err});
		apb(1'b1, KPI_OFF_PE, 8'hFF);
		rchk(KPI_OFF_PE, {24'h0, KPI_PIN_MASK});
		apb(1'b1, KPI_OFF_ES, 8'hFF);
		rchk(KPI_OFF_ES, {24'h0, KPI_PIN_MASK});
		apb(1'b1, KPI_OFF_ES, 8'h00);
		apb(1'b1, KPI_OFF_SC, 8'hFF);
		rchk(KPI_OFF_SC, 32'h3);
		apb(1'b1, KPI_OFF_SC, 8'h06);
		pin_set(8'hFE);
		rchk(KPI_OFF_SC, 32'hA);
		ichk(1'b1);
		apb(1'b1, KPI_OFF_SC, 8'h06);
		rchk(KPI_OFF_SC, 32'h2);
		ichk(1'b0);
		apb(1'b1, KPI_OFF_PE, 8'h36);
		pin_set(8'hFF);
		pin_set(8'hFE);
		rchk(KPI_OFF_SC, 32'h2);
		pin_set(8'hEE);
		rchk(KPI_OFF_SC, 32'hA);
		apb(1'b1, KPI_OFF_ES, 8'h10);
		apb(1'b1, KPI_OFF_SC, 8'h06);
		rchk(KPI_OFF_SC, 32'h2);
		pin_set(8'hFE);
		rchk(KPI_OFF_SC, 32'hA);
		apb(1'b1, KPI_OFF_SC, 8'h07);
		repeat (4) @(posedge pclk);
		rchk(KPI_OFF_SC, 32'hB);
		ichk(1'b1);
		pin_set(8'hEE);
		apb(1'b1, KPI_OFF_SC, 8'h07);
		rchk(KPI_OFF_SC, 32'h3);
		apb(1'b1, KPI_OFF_SC, 8'h01);
		pin_set(8'hFE);
		rchk(KPI_OFF_SC, 32'h9);
		ichk(1'b0);
		give_verdict();
	end

	// Run needs well under a thousand cycles; this only cuts a hang
	initial
	begin
		repeat (20000) @(posedge pclk);
		fails++;
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
